/* core/fpc_counters.sv */
/*
 * Two fast up/down pulse counters and two one-second-gate rate meters with a Wishbone
 * register slave and per-cycle threshold contacts.
 * Assumes pulse inputs asynchronous to SYS_CLK and CYCLE_TICK a one-cycle pulse from logic
 * on SYS_CLK marking each program cycle.
 */
`timescale 1ns/10ps
module fpc_counters
    import fpc_pkg::*;
#(
    parameter int unsigned GATE_CYCLES = FPC_GATE_CYC
) (
    input  wire logic        SYS_CLK,
    input  wire logic        RST,
    input  wire logic        INPUT_ONE,
    input  wire logic        INPUT_TWO,
    input  wire logic        INPUT_THREE,
    input  wire logic        INPUT_FOUR,
    input  wire logic        CYCLE_TICK,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    output logic      [3:0]  CONTACT
);
    // Byte-lane merge for writes.
    function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] dat,
                                             input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = dat[8*b +: 8];
            end
        end
        return res;
    endfunction : wb_merge

    // Setpoints above the top of the range are held at the top.
    function automatic logic [15:0] clamp_sp(input logic [15:0] v);
        return (v > FPC_VAL_MAX) ? FPC_VAL_MAX : v;
    endfunction : clamp_sp

    // Setpoint write: merge the lanes, then hold anything past the top of the range there.
    // Bits above [15] count too, so a large word never wraps into a small setpoint.
    function automatic logic [15:0] sp_write(input logic [15:0] old, input logic [31:0] dat,
                                             input logic [3:0] sel);
        logic [31:0] m;
        m = wb_merge({16'h0000, old}, dat, sel);
        return (m[31:16] != 16'h0000) ? FPC_VAL_MAX : clamp_sp(m[15:0]);
    endfunction : sp_write

    logic [31:0]  ctrl_ff;
    logic [31:0]  mode_ff;
    logic [15:0]  sp_ff [4];
    logic [15:0]  pc_val_ff [2];
    logic [15:0]  rm_val_ff [2];
    logic [15:0]  rm_cnt_ff [2];
    logic [3:0]   sync1_ff;
    logic [3:0]   sync2_ff;
    logic [3:0]   prev_ff;
    logic [3:0]   rise;
    logic [3:0]   cmp_live;
    logic [3:0]   contact_ff;
    logic [31:0]  gate_cnt_ff;
    logic         gate_end;
    logic         run_prev_ff;
    logic         run_start;
    logic         wb_req;
    logic         wb_wr;
    logic [31:0]  rd_data;
    logic [31:0]  dat_ff;
    logic         ack_ff;
    fpc_gate_e    gate_ff;
    fpc_gate_e    nxt_gate;
    fpc_pc_ctrl_s pc_ctrl [2];
    fpc_rm_ctrl_s rm_ctrl [2];
    logic         run;

    assign run = ctrl_ff[FPC_RUN_BIT];

    // Unpack the control word into per-counter carriers, one field at a time.
    // A whole-slice cast would put the first member on the top bit, so enable sits lowest.
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            pc_ctrl[i].en         = ctrl_ff[FPC_PC_BASE + 4*i];
            pc_ctrl[i].dir        = ctrl_ff[FPC_PC_BASE + 4*i + 1];
            pc_ctrl[i].clr        = ctrl_ff[FPC_PC_BASE + 4*i + 2];
            pc_ctrl[i].retain     = ctrl_ff[FPC_PC_BASE + 4*i + 3];
            rm_ctrl[i].en         = ctrl_ff[FPC_RM_BASE + 4*i];
            rm_ctrl[i].clr        = ctrl_ff[FPC_RM_BASE + 4*i + 1];
            rm_ctrl[i].dir_unused = ctrl_ff[FPC_RM_BASE + 4*i + 2];
        end
    end

    // Wishbone slave: ack one cycle after the request, then dropped for a cycle.
    // A write lands at the edge where the master samples ack, not one edge earlier.
    assign wb_req = WB_CYC_I & WB_STB_I & ~ack_ff;
    assign wb_wr  = WB_CYC_I & WB_STB_I & WB_WE_I & ack_ff;

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= wb_req;
        end
    end

    // Read mux; unmapped addresses read zero and are still acknowledged.
    always_comb begin
        rd_data = 32'h0000_0000;
        case (WB_ADR_I)
            FPC_CTRL_ADR: rd_data = ctrl_ff;
            FPC_MODE_ADR: rd_data = mode_ff;
            FPC_STAT_ADR: rd_data = {24'h00_0000, cmp_live, contact_ff};
            default: begin
                for (int i = 0; i < 4; i++) begin
                    if (WB_ADR_I == FPC_SP0_ADR + 8'(4*i)) begin
                        rd_data = {16'h0000, sp_ff[i]};
                    end
                end
                for (int i = 0; i < 2; i++) begin
                    if (WB_ADR_I == FPC_ACT0_ADR + 8'(4*i)) begin
                        rd_data = {16'h0000, pc_val_ff[i]};
                    end
                    if (WB_ADR_I == FPC_ACT0_ADR + 8'(4*i + 8)) begin
                        rd_data = {16'h0000, rm_val_ff[i]};
                    end
                end
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            dat_ff <= 32'h0000_0000;
        end else if (wb_req && !WB_WE_I) begin
            dat_ff <= rd_data;
        end
    end

    // Control and mode registers; a set mode bit in [3:0] selects the hard-wired fast function.
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            ctrl_ff <= FPC_CTRL_RST;
            mode_ff <= FPC_MODE_RST;
        end else if (wb_wr && WB_ADR_I == FPC_CTRL_ADR) begin
            ctrl_ff <= wb_merge(ctrl_ff, WB_DAT_I, WB_SEL_I);
        end else if (wb_wr && WB_ADR_I == FPC_MODE_ADR) begin
            mode_ff <= wb_merge(mode_ff, WB_DAT_I, WB_SEL_I) & FPC_MODE_RST;
        end
    end

    // Setpoints, clamped to 32000; rate setpoints above 1000 are kept but never reached.
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < 4; i++) begin
                sp_ff[i] <= FPC_VAL_ZERO;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (wb_wr && WB_ADR_I == FPC_SP0_ADR + 8'(4*i)) begin
                    sp_ff[i] <= sp_write(sp_ff[i], WB_DAT_I, WB_SEL_I);
                end
            end
        end
    end

    // Two-stage synchronisers on the four pulse pins; edges look only at the second stage.
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            sync1_ff <= 4'h0;
            sync2_ff <= 4'h0;
            prev_ff  <= 4'h0;
        end else begin
            sync1_ff <= {INPUT_FOUR, INPUT_THREE, INPUT_TWO, INPUT_ONE};
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    assign rise = sync2_ff & ~prev_ff;

    // Run edge; a non-retentive pulse counter starts again from zero on entering run.
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            run_prev_ff <= 1'b0;
        end else begin
            run_prev_ff <= run;
        end
    end

    assign run_start = run & ~run_prev_ff;

    // Pulse counters. Direction flips saturation side; a held pin costs nothing since only
    // edges count, so rates up to the 1 kHz limit are far inside the clock budget.
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            pc_val_ff[0] <= FPC_VAL_ZERO;
            pc_val_ff[1] <= FPC_VAL_ZERO;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (pc_ctrl[i].clr) begin
                    pc_val_ff[i] <= FPC_VAL_ZERO;
                end else if (run_start && !pc_ctrl[i].retain) begin
                    pc_val_ff[i] <= FPC_VAL_ZERO;
                end else if (run && mode_ff[i] && pc_ctrl[i].en && rise[i]) begin
                    if (!pc_ctrl[i].dir) begin
                        if (pc_val_ff[i] < FPC_VAL_MAX) begin
                            pc_val_ff[i] <= pc_val_ff[i] + 16'h0001;
                        end
                    end else if (pc_val_ff[i] != FPC_VAL_ZERO) begin
                        pc_val_ff[i] <= pc_val_ff[i] - 16'h0001;
                    end
                end
            end
        end
    end

    // Gate sequencer: one-second windows, two cycles apart, while run is set and any rate meter is enabled.
    always_comb begin
        nxt_gate = gate_ff;
        case (gate_ff)
            FPC_GATE_IDLE: begin
                if (run && (rm_ctrl[0].en || rm_ctrl[1].en)) begin
                    nxt_gate = FPC_GATE_OPEN;
                end
            end
            FPC_GATE_OPEN: begin
                if (gate_end) begin
                    nxt_gate = FPC_GATE_LOAD;
                end
            end
            FPC_GATE_LOAD: begin
                nxt_gate = FPC_GATE_IDLE;
            end
            default: begin
                nxt_gate = FPC_GATE_IDLE;
            end
        endcase
    end

    assign gate_end = (gate_ff == FPC_GATE_OPEN) && (gate_cnt_ff == GATE_CYCLES - 1);

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            gate_ff     <= FPC_GATE_IDLE;
            gate_cnt_ff <= 32'h0000_0000;
        end else begin
            gate_ff <= nxt_gate;
            if (gate_ff == FPC_GATE_OPEN && !gate_end) begin
                gate_cnt_ff <= gate_cnt_ff + 32'h0000_0001;
            end else begin
                gate_cnt_ff <= 32'h0000_0000;
            end
        end
    end

    // Rate meters: count edges in the gate, publish at its end; direction is never read.
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < 2; i++) begin
                rm_cnt_ff[i] <= FPC_VAL_ZERO;
                rm_val_ff[i] <= FPC_VAL_ZERO;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (!rm_ctrl[i].en || rm_ctrl[i].clr || !run || !mode_ff[i+2]) begin
                    rm_cnt_ff[i] <= FPC_VAL_ZERO;
                    rm_val_ff[i] <= FPC_VAL_ZERO;
                end else if (gate_end) begin
                    rm_val_ff[i] <= rm_cnt_ff[i] + 16'(rise[i+2]);
                    rm_cnt_ff[i] <= FPC_VAL_ZERO;
                end else if (gate_ff == FPC_GATE_OPEN && rise[i+2] &&
                             rm_cnt_ff[i] < FPC_VAL_MAX) begin
                    rm_cnt_ff[i] <= rm_cnt_ff[i] + 16'h0001;
                end
            end
        end
    end

    // Live comparison; a fresh lower measurement drops it at once.
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            cmp_live[i]   = pc_val_ff[i] >= sp_ff[i];
            cmp_live[i+2] = rm_val_ff[i] >= sp_ff[i+2];
        end
    end

    // Contacts only move on the program-cycle tick, so the program sees a steady value
    // for a whole cycle at the price of up to one cycle of lag.
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            contact_ff <= 4'h0;
        end else if (CYCLE_TICK) begin
            contact_ff <= cmp_live;
        end
    end

    assign CONTACT  = contact_ff;
    assign WB_DAT_O = dat_ff;
    assign WB_ACK_O = ack_ff;

    // Checks.
    sequence s_up_pulse;
        run && mode_ff[0] && pc_ctrl[0].en && !pc_ctrl[0].clr && !run_start && rise[0]
            && !pc_ctrl[0].dir;
    endsequence

    property p_contact_hold;
        @(posedge SYS_CLK) disable iff (RST) !CYCLE_TICK |=> $stable(CONTACT);
    endproperty
    a_contact_hold: assert property (p_contact_hold)
        else $error("Contact changed without a cycle tick.");

    property p_contact_value;
        @(posedge SYS_CLK) disable iff (RST) CYCLE_TICK |=> CONTACT == $past(cmp_live);
    endproperty
    a_contact_value: assert property (p_contact_value)
        else $error("Contact does not match the comparison at the tick.");

    property p_cmp;
        @(posedge SYS_CLK) disable iff (RST) CYCLE_TICK
            |=> CONTACT[0] == ($past(pc_val_ff[0]) >= $past(sp_ff[0]));
    endproperty
    a_cmp: assert property (p_cmp)
        else $error("Comparison result wrong for pulse counter.");

    property p_clear;
        @(posedge SYS_CLK) disable iff (RST) pc_ctrl[0].clr ##1 pc_ctrl[0].clr
            |-> pc_val_ff[0] == FPC_VAL_ZERO;
    endproperty
    a_clear: assert property (p_clear)
        else $error("Pulse counter not held at zero under clear.");

    property p_sat;
        @(posedge SYS_CLK) disable iff (RST) pc_val_ff[1] <= FPC_VAL_MAX;
    endproperty
    a_sat: assert property (p_sat)
        else $error("Pulse counter above its ceiling.");

    property p_count_up;
        @(posedge SYS_CLK) disable iff (RST) s_up_pulse ##0 pc_val_ff[0] < FPC_VAL_MAX
            |=> pc_val_ff[0] == $past(pc_val_ff[0]) + 16'h0001;
    endproperty
    a_count_up: assert property (p_count_up)
        else $error("Pulse counter missed an up count.");

    property p_hold;
        @(posedge SYS_CLK) disable iff (RST) !pc_ctrl[0].en && !pc_ctrl[0].clr && !run_start
            |=> $stable(pc_val_ff[0]);
    endproperty
    a_hold: assert property (p_hold)
        else $error("Disabled pulse counter changed.");

    property p_rm_off;
        @(posedge SYS_CLK) disable iff (RST) !rm_ctrl[0].en |=> rm_val_ff[0] == FPC_VAL_ZERO;
    endproperty
    a_rm_off: assert property (p_rm_off)
        else $error("Disabled rate meter not cleared.");

    property p_rm_gate;
        @(posedge SYS_CLK) disable iff (RST) !gate_end && rm_ctrl[0].en && !rm_ctrl[0].clr
            && run && mode_ff[2] ##1 rm_ctrl[0].en && !rm_ctrl[0].clr && run && mode_ff[2]
            |-> $stable(rm_val_ff[0]);
    endproperty
    a_rm_gate: assert property (p_rm_gate)
        else $error("Rate value changed away from a gate end.");

    property p_sync;
        @(posedge SYS_CLK) disable iff (RST) rise[0] |-> $past(sync1_ff[0], 1)
            && !$past(sync1_ff[0], 2);
    endproperty
    a_sync: assert property (p_sync)
        else $error("Edge not derived from the two-stage synchroniser.");
endmodule : fpc_counters

/* core/fpc_pkg.sv */
/*
 * Package of the fast pulse and rate counter block: register map, control field positions,
 * reset values, limits, gate timing and the carrier types shared by the block.
 * Assumes a 20 MHz system clock and a 32-bit classic Wishbone register bus.
 */
package fpc_pkg;
    // Register byte addresses.
    localparam logic [7:0] FPC_CTRL_ADR   = 8'h00;
    localparam logic [7:0] FPC_MODE_ADR   = 8'h04;
    localparam logic [7:0] FPC_SP0_ADR    = 8'h08; // Setpoints at 08, 0C, 10, 14.
    localparam logic [7:0] FPC_ACT0_ADR   = 8'h18; // Actual values at 18, 1C, 20, 24.
    localparam logic [7:0] FPC_STAT_ADR   = 8'h28;
    // Control register fields.
    localparam int FPC_RUN_BIT     = 0;
    localparam int FPC_PC_BASE     = 4;  // Pulse counter n at 4 + 4n: en, dir, clr, retain.
    localparam int FPC_RM_BASE     = 12; // Rate meter n at 12 + 4n: en, clr, unused dir.
    localparam int FPC_SHOW_BASE   = 8;  // Mode register: modes in [3:0], show flags in [11:8].
    localparam logic [31:0] FPC_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] FPC_MODE_RST = 32'h0000_0F0F;
    // Value limits.
    localparam logic [15:0] FPC_VAL_MAX = 16'h7D00; // 32000.
    localparam logic [15:0] FPC_VAL_ZERO = 16'h0000;
    // Gate timing.
    localparam int unsigned FPC_CLK_HZ     = 20_000_000;
    localparam int unsigned FPC_GATE_MS    = 1000;
    localparam int unsigned FPC_GATE_CYC   = FPC_GATE_MS * (FPC_CLK_HZ / 1000);
    // Carrier types.
    typedef struct packed {
        logic en;
        logic dir;
        logic clr;
        logic retain;
    } fpc_pc_ctrl_s;
    typedef struct packed {
        logic en;
        logic clr;
        logic dir_unused;
    } fpc_rm_ctrl_s;
    typedef enum logic [1:0] {
        FPC_GATE_IDLE = 2'b00,
        FPC_GATE_OPEN = 2'b01,
        FPC_GATE_LOAD = 2'b11
    } fpc_gate_e;
endpackage : fpc_pkg

/* bench/fpc_pulse_src.sv */
/*
 * Behavioural model of the four square-wave pulse sources that feed the counter pins.
 * Assumes the bench calls start() from a process synchronised to clk, and picks a compressed
 * time base in which MIN_HALF and MAX_HALF stand for the shortest and longest legal phases.
 */
`timescale 1ns/10ps
module fpc_pulse_src #(
    parameter int MIN_HALF = 10000,
    parameter int MAX_HALF = 2500000
) (
    input  wire logic       clk,
    output logic      [3:0] pins
);
    int half [4] = '{default: MIN_HALF};
    int rem  [4] = '{default: 0};
    int cnt  [4] = '{default: 0};
    logic [3:0] lvl = 4'h0;

    // Pins rest low until a burst or a free-running wave is started.
    assign pins = lvl;

    // Requests a number of phase toggles on one pin; a negative count runs free.
    // The phase is clamped so that no source ever leaves the legal band.
    task automatic start(input int ch, input int h, input int toggles);
        int hc;
        hc = (h < MIN_HALF) ? MIN_HALF : ((h > MAX_HALF) ? MAX_HALF : h);
        @(posedge clk);
        half[ch] <= hc;
        rem[ch]  <= toggles;
    endtask : start

    // Equal high and low phases give the preferred 1:1 square wave.
    always @(posedge clk) begin
        for (int ch = 0; ch < 4; ch++) begin
            if (rem[ch] != 0) begin
                if (cnt[ch] + 1 >= half[ch]) begin
                    cnt[ch]  <= 0;
                    lvl[ch] <= ~lvl[ch];
                    if (rem[ch] > 0) begin
                        rem[ch] <= rem[ch] - 1;
                    end
                end else begin
                    cnt[ch] <= cnt[ch] + 1;
                end
            end
        end
    end
endmodule : fpc_pulse_src

/* bench/fpc_counters_bench.sv */
/*
 * Self-checking bench of the pulse counter and rate meter block, one task per scenario.
 * Assumes a 200-cycle gate stands for one second and the pulse sources share that time base.
 */
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin fail_count++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module fpc_counters_bench
    import fpc_pkg::*;
;
    localparam int GATE = 200;
    localparam int HALF = 20;
    localparam int GWAIT = 3 * (GATE + 2) + 20;
    logic        sys_clk    = 1'b0;
    logic        rst        = 1'b1;
    logic        cycle_tick = 1'b0;
    logic        wb_cyc     = 1'b0;
    logic        wb_stb     = 1'b0;
    logic        wb_we      = 1'b0;
    logic [7:0]  wb_adr     = 8'h00;
    logic [3:0]  wb_sel     = 4'h0;
    logic [31:0] wb_dat_w   = 32'h0000_0000;
    logic [31:0] wb_dat_r;
    logic        wb_ack;
    logic [3:0]  contact;
    wire  [3:0]  pins;
    int          fail_count = 0;
    int          n_tests    = 0;

    // A 50 ns period gives the 20 MHz system clock.
    always #25 sys_clk = ~sys_clk;

    // With a 200-cycle second, 4 Hz is a 25-cycle phase; 1 kHz cannot be shown at this scale.
    fpc_pulse_src #(.MIN_HALF(10), .MAX_HALF(GATE / 8)) u_src (.clk(sys_clk), .pins(pins));

    fpc_counters #(.GATE_CYCLES(GATE)) u_dut (
        .SYS_CLK(sys_clk), .RST(rst), .INPUT_ONE(pins[0]), .INPUT_TWO(pins[1]),
        .INPUT_THREE(pins[2]), .INPUT_FOUR(pins[3]), .CYCLE_TICK(cycle_tick),
        .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb), .WB_WE_I(wb_we), .WB_ADR_I(wb_adr),
        .WB_SEL_I(wb_sel), .WB_DAT_I(wb_dat_w), .WB_DAT_O(wb_dat_r), .WB_ACK_O(wb_ack),
        .CONTACT(contact));

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out

    // One classic cycle: request held until ack is sampled, released at that edge.
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                           output logic [31:0] rd);
        int i;
        @(posedge sys_clk);
        wb_cyc   <= 1'b1;
        wb_stb   <= 1'b1;
        wb_we    <= we;
        wb_adr   <= adr;
        wb_sel   <= 4'hF;
        wb_dat_w <= wd;
        for (i = 0; i < 20; i++) begin
            @(posedge sys_clk);
            if (wb_ack === 1'b1) break;
        end
        rd = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
        if (i == 20) begin
            fail_count++;
            $display("[ERR] bus ack expected 1 seen 0");
            close_out();
        end
    endtask : wb_xfer

    task automatic wb_wr(input logic [7:0] adr, input logic [31:0] d);
        logic [31:0] unused_rd;
        wb_xfer(1'b1, adr, d, unused_rd);
    endtask : wb_wr

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] ex, input string nm);
        logic [31:0] d;
        wb_xfer(1'b0, adr, 32'h0000_0000, d);
        `CHK(nm, ex, d)
    endtask : rd_chk

    // Sends n whole pulses, then lets the synchroniser and edge detector settle.
    task automatic pulses(input int ch, input int n);
        int i;
        u_src.start(ch, HALF, 2 * n);
        @(posedge sys_clk);
        for (i = 0; i < 2 * HALF * n + 50 && u_src.rem[ch] != 0; i++) @(posedge sys_clk);
        if (u_src.rem[ch] != 0) begin
            fail_count++;
            $display("[ERR] pulse burst expected done seen busy");
            close_out();
        end
        repeat (8) @(posedge sys_clk);
    endtask : pulses

    // One program-cycle tick; the captured contacts are judged a cycle later.
    task automatic tick_chk(input logic [3:0] ex, input string nm);
        @(posedge sys_clk);
        cycle_tick <= 1'b1;
        @(posedge sys_clk);
        cycle_tick <= 1'b0;
        @(posedge sys_clk);
        `CHK(nm, ex, contact)
    endtask : tick_chk

    task automatic t_reset();
        rd_chk(FPC_CTRL_ADR, FPC_CTRL_RST, "ctrl reset");
        rd_chk(FPC_MODE_ADR, FPC_MODE_RST, "mode reset");
        rd_chk(FPC_SP0_ADR, 32'h0000_0000, "setpoint reset");
        rd_chk(FPC_ACT0_ADR, 32'h0000_0000, "actual reset");
        rd_chk(8'h3C, 32'h0000_0000, "unmapped read");
        `CHK("contact reset", 4'h0, contact)
        tick_chk(4'hF, "contact equal zero");
    endtask : t_reset

    task automatic t_count_up();
        wb_wr(FPC_CTRL_ADR, 32'h0000_0011);
        pulses(0, 5);
        rd_chk(FPC_ACT0_ADR, 32'h0000_0005, "pulse a up");
        rd_chk(FPC_ACT0_ADR + 8'h04, 32'h0000_0000, "pulse b idle");
        wb_wr(FPC_SP0_ADR, 32'h0000_0005);
        wb_wr(FPC_SP0_ADR + 8'h04, 32'h0000_0001);
        tick_chk(4'b1101, "contact at setpoint");
        wb_wr(FPC_SP0_ADR, 32'h0000_0006);
        repeat (4) @(posedge sys_clk);
        `CHK("contact held", 4'b1101, contact)
        rd_chk(FPC_STAT_ADR, 32'h0000_00CD, "status live and held");
        tick_chk(4'b1100, "contact below");
    endtask : t_count_up

    task automatic t_hold_and_mode();
        wb_wr(FPC_CTRL_ADR, 32'h0000_0001);
        pulses(0, 3);
        rd_chk(FPC_ACT0_ADR, 32'h0000_0005, "hold unenabled");
        wb_wr(FPC_CTRL_ADR, 32'h0000_0011);
        wb_wr(FPC_MODE_ADR, 32'h0000_0A0E);
        rd_chk(FPC_MODE_ADR, 32'h0000_0A0E, "mode readback");
        pulses(0, 2);
        rd_chk(FPC_ACT0_ADR, 32'h0000_0005, "mode off hold");
        wb_wr(FPC_MODE_ADR, FPC_MODE_RST);
    endtask : t_hold_and_mode

    task automatic t_down_clear();
        wb_wr(FPC_CTRL_ADR, 32'h0000_0031);
        pulses(0, 7);
        rd_chk(FPC_ACT0_ADR, 32'h0000_0000, "down to floor");
        wb_wr(FPC_CTRL_ADR, 32'h0000_0011);
        pulses(0, 4);
        rd_chk(FPC_ACT0_ADR, 32'h0000_0004, "up from floor");
        wb_wr(FPC_CTRL_ADR, 32'h0000_0051);
        pulses(0, 3);
        rd_chk(FPC_ACT0_ADR, 32'h0000_0000, "clear held");
        wb_wr(FPC_CTRL_ADR, 32'h0000_0011);
        pulses(0, 2);
        rd_chk(FPC_ACT0_ADR, 32'h0000_0002, "after clear");
    endtask : t_down_clear

    task automatic t_retain();
        wb_wr(FPC_CTRL_ADR, 32'h0000_0191);
        pulses(0, 3);
        pulses(1, 4);
        rd_chk(FPC_ACT0_ADR + 8'h04, 32'h0000_0004, "pulse b count");
        wb_wr(FPC_CTRL_ADR, 32'h0000_0190);
        wb_wr(FPC_CTRL_ADR, 32'h0000_0191);
        rd_chk(FPC_ACT0_ADR, 32'h0000_0005, "retained");
        rd_chk(FPC_ACT0_ADR + 8'h04, 32'h0000_0000, "not retained");
    endtask : t_retain

    // Direction bit of rate meter a is set on purpose; it must have no effect.
    task automatic t_rate();
        u_src.start(2, 10, -1);
        u_src.start(3, 25, -1);
        wb_wr(FPC_SP0_ADR + 8'h08, 32'h0000_000A);
        wb_wr(FPC_CTRL_ADR, 32'h0001_5001);
        repeat (GWAIT) @(posedge sys_clk);
        rd_chk(FPC_ACT0_ADR + 8'h08, 32'h0000_000A, "rate a");
        rd_chk(FPC_ACT0_ADR + 8'h0C, 32'h0000_0004, "rate b");
        tick_chk(4'b1100, "rate contact set");
        u_src.start(2, 20, -1);
        repeat (GWAIT) @(posedge sys_clk);
        rd_chk(FPC_ACT0_ADR + 8'h08, 32'h0000_0005, "rate remeasured");
        tick_chk(4'b1000, "rate contact drop");
        wb_wr(FPC_SP0_ADR + 8'h08, 32'h0000_9C40);
        rd_chk(FPC_SP0_ADR + 8'h08, 32'h0000_7D00, "rate setpoint cap");
        wb_wr(FPC_SP0_ADR, 32'h0000_7D00);
        rd_chk(FPC_SP0_ADR, 32'h0000_7D00, "pulse setpoint max");
        wb_wr(FPC_CTRL_ADR, 32'h0001_4001);
        rd_chk(FPC_ACT0_ADR + 8'h08, 32'h0000_0000, "disable zeroes");
        wb_wr(FPC_CTRL_ADR, 32'h0003_0001);
        rd_chk(FPC_ACT0_ADR + 8'h0C, 32'h0000_0000, "rate clear");
    endtask : t_rate

    // Main sequence: reset for ten cycles, then each scenario in turn.
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset();
        t_count_up();
        t_hold_and_mode();
        t_down_clear();
        t_retain();
        t_rate();
        close_out();
    end
endmodule : fpc_counters_bench
